// ---- src/decrement_skip_execution.sv ----
// decrement-and-skip execution unit with axi4-lite control registers
// Behaviour
// - read the addressed data register and subtract one to form the result
// - destination bit zero puts the result in the working accumulator only
// - destination bit one writes the result back to the data register
// - skip-if-zero variant skips only when the result is zero
// - skip-if-nonzero variant skips only when the result is not zero
// - a skip drops the prefetched word and runs a no_operation, two cycles
// - skipping a two-word instruction costs three instruction cycles in total
// - bank-access bit zero addresses the access bank, not the selected bank
// - extended set, access bit zero and f up to 95 use indexed offset
// - each instruction is one word; a non-skipping run takes one cycle
module decrement_skip_execution
  import dskip_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // instruction stream
  input wire logic instr_valid,
  input wire logic [15:0] instr_word,
  input wire logic next_two_word,
  output logic instr_ready_q,
  output logic discard_q,
  output logic nop_q,
  output logic done_q,
  // data memory
  output logic [11:0] mem_addr_q,
  input wire logic [7:0] mem_rdata,
  output logic mem_we_q,
  output logic [7:0] mem_wdata_q,
  // axi4-lite slave
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ****************************************************************
  // functions
  // ****************************************************************
  // operand address: access bank, selected bank or indexed offset
  function automatic logic [11:0] resolve_addr(input decoded_s dec, input logic [3:0] bank,
                                               input logic ext, input logic [11:0] base);
    logic [11:0] a;
    a = {bank, dec.f};
    if (!dec.access) begin
      if (ext && dec.f <= ACCESS_SPLIT) begin
        a = base + {4'h0, dec.f};
      end else if (dec.f <= ACCESS_SPLIT) begin
        a = {ACCESS_LOW_BANK, dec.f};
      end else begin
        a = {ACCESS_HIGH_BANK, dec.f};
      end
    end
    return a;
  endfunction

  // merge a bus write into an old word lane by lane
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic mapped(input logic [4:0] a);
    return a == REG_CTRL || a == REG_BANK || a == REG_WREG || a == REG_INDEX ||
           a == REG_STATUS;
  endfunction

  // ****************************************************************
  // state
  // ****************************************************************
  logic aw_held_q, aw_held_d, w_held_q, w_held_d;
  logic [4:0] aw_addr_q, aw_addr_d;
  logic [31:0] w_data_q, w_data_d;
  logic [3:0] w_strb_q, w_strb_d;
  logic bvalid_d, rvalid_d;
  logic [1:0] bresp_d, rresp_d;
  logic [31:0] rdata_d;
  logic ext_q, ext_d;
  logic [3:0] bank_q, bank_d;
  logic [7:0] w_q, w_d;
  logic [11:0] index_q, index_d;
  logic [7:0] result_q, result_d;
  logic skipped_q, skipped_d;
  logic [1:0] cycles_q, cycles_d;
  logic foreign_q, foreign_d;
  exec_state_e state_q, state_d;
  decoded_s dec_q, dec_d;
  logic two_word_q, two_word_d;
  logic ready_d, discard_d, nop_d, done_d, mem_we_d;
  logic [11:0] mem_addr_d;
  logic [7:0] mem_wdata_d;
  logic wr_fire, rd_fire, accept, foreign;
  logic [5:0] opcode;
  logic [7:0] dec_result;
  logic take_skip;
  logic [31:0] status_word;

  assign wr_fire = aw_held_q && w_held_q && !s_axi_bvalid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign opcode = instr_word[15:10];
  // only the two prefixes are taken; anything else is refused and noted
  assign foreign = opcode != OP_SKIP_ZERO && opcode != OP_SKIP_NONZERO;
  assign accept = state_q == ST_IDLE && instr_valid && instr_ready_q && !foreign;
  assign dec_result = mem_rdata - 8'h01;
  assign take_skip = dec_q.nonzero_kind ? (dec_result != 8'h00)
                                        : (dec_result == 8'h00);
  assign status_word = {19'h0, foreign_q, 1'b0, cycles_q, skipped_q, result_q};

  // ****************************************************************
  // axi4-lite handshake
  // ****************************************************************
  // address and data are caught separately, so either may come first
  always_comb begin
    aw_held_d = aw_held_q;
    aw_addr_d = aw_addr_q;
    w_held_d = w_held_q;
    w_data_d = w_data_q;
    w_strb_d = w_strb_q;
    bvalid_d = s_axi_bvalid;
    bresp_d = s_axi_bresp;
    rvalid_d = s_axi_rvalid;
    rresp_d = s_axi_rresp;
    rdata_d = s_axi_rdata;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_held_d = 1'b1;
      aw_addr_d = s_axi_awaddr[4:0];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_held_d = 1'b1;
      w_data_d = s_axi_wdata;
      w_strb_d = s_axi_wstrb;
    end
    if (wr_fire) begin
      aw_held_d = 1'b0;
      w_held_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = mapped(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bvalid && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    if (rd_fire) begin
      rvalid_d = 1'b1;
      rresp_d = mapped(s_axi_araddr[4:0]) ? RESP_OKAY : RESP_SLVERR;
      case (s_axi_araddr[4:0])
        REG_CTRL: rdata_d = {31'h0, ext_q};
        REG_BANK: rdata_d = {28'h0, bank_q};
        REG_WREG: rdata_d = {24'h0, w_q};
        REG_INDEX: rdata_d = {20'h0, index_q};
        REG_STATUS: rdata_d = status_word;
        default: rdata_d = 32'h0;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
  end

  // ready flops are refreshed every edge from the held flags and the pending bvalid/rvalid responses
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      aw_held_q <= 1'b0;
      aw_addr_q <= 5'h0;
      w_held_q <= 1'b0;
      w_data_q <= 32'h0;
      w_strb_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= RESP_OKAY;
      s_axi_rdata <= 32'h0;
    end else begin
      aw_held_q <= aw_held_d;
      aw_addr_q <= aw_addr_d;
      w_held_q <= w_held_d;
      w_data_q <= w_data_d;
      w_strb_q <= w_strb_d;
      s_axi_awready <= !aw_held_d && !bvalid_d;
      s_axi_wready <= !w_held_d && !bvalid_d;
      s_axi_bvalid <= bvalid_d;
      s_axi_bresp <= bresp_d;
      s_axi_arready <= !rvalid_d;
      s_axi_rvalid <= rvalid_d;
      s_axi_rresp <= rresp_d;
      s_axi_rdata <= rdata_d;
    end
  end

  // ****************************************************************
  // registers and execution
  // ****************************************************************
  // a result for the accumulator wins over a bus write in the same cycle
  always_comb begin
    logic [31:0] m;
    m = 32'h0;
    ext_d = ext_q;
    bank_d = bank_q;
    w_d = w_q;
    index_d = index_q;
    result_d = result_q;
    skipped_d = skipped_q;
    cycles_d = cycles_q;
    foreign_d = foreign_q;
    state_d = state_q;
    dec_d = dec_q;
    two_word_d = two_word_q;
    discard_d = 1'b0;
    done_d = 1'b0;
    mem_we_d = 1'b0;
    mem_addr_d = mem_addr_q;
    mem_wdata_d = mem_wdata_q;
    if (wr_fire) begin
      case (aw_addr_q)
        REG_CTRL: begin
          m = merge({31'h0, ext_q}, w_data_q, w_strb_q);
          ext_d = m[CTRL_EXT_BIT];
        end
        REG_BANK: begin
          m = merge({28'h0, bank_q}, w_data_q, w_strb_q);
          bank_d = m[3:0];
        end
        REG_WREG: begin
          m = merge({24'h0, w_q}, w_data_q, w_strb_q);
          w_d = m[7:0];
        end
        REG_INDEX: begin
          m = merge({20'h0, index_q}, w_data_q, w_strb_q);
          index_d = m[11:0];
        end
        REG_STATUS: begin
          // write one to clear the refused-opcode flag
          if (w_strb_q[1] && w_data_q[STATUS_FOREIGN_BIT]) begin
            foreign_d = 1'b0;
          end
        end
        default: m = 32'h0;
      endcase
    end
    // a refused opcode in the clearing cycle still leaves the flag set
    if (state_q == ST_IDLE && instr_valid && instr_ready_q && foreign) begin
      foreign_d = 1'b1;
    end
    case (state_q)
      ST_IDLE: begin
        if (accept) begin
          dec_d = '{nonzero_kind: opcode == OP_SKIP_NONZERO, dest: instr_word[9],
                    access: instr_word[8], f: instr_word[7:0]};
          mem_addr_d = resolve_addr(dec_d, bank_q, ext_q, index_q);
          state_d = ST_EXEC;
        end
      end
      ST_EXEC: begin
        result_d = dec_result;
        two_word_d = next_two_word;
        skipped_d = take_skip;
        if (dec_q.dest) begin
          mem_we_d = 1'b1;
          mem_wdata_d = dec_result;
        end else begin
          w_d = dec_result;
        end
        if (take_skip) begin
          discard_d = 1'b1;
          state_d = ST_SKIP;
        end else begin
          cycles_d = CYC_PLAIN;
          done_d = 1'b1;
          state_d = ST_IDLE;
        end
      end
      ST_SKIP: begin
        if (two_word_q) begin
          state_d = ST_SKIP2;
        end else begin
          cycles_d = CYC_SKIP;
          done_d = 1'b1;
          state_d = ST_IDLE;
        end
      end
      ST_SKIP2: begin
        cycles_d = CYC_SKIP_LONG;
        done_d = 1'b1;
        state_d = ST_IDLE;
      end
      default: state_d = ST_IDLE;
    endcase
    nop_d = state_d == ST_SKIP || state_d == ST_SKIP2;
    ready_d = state_d == ST_IDLE;
  end

  // register stage of the execution group
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ext_q <= CTRL_RESET;
      bank_q <= BANK_RESET;
      w_q <= WREG_RESET;
      index_q <= INDEX_RESET;
      result_q <= 8'h00;
      skipped_q <= 1'b0;
      cycles_q <= 2'h0;
      foreign_q <= 1'b0;
      state_q <= ST_IDLE;
      dec_q <= '0;
      two_word_q <= 1'b0;
      instr_ready_q <= 1'b0;
      discard_q <= 1'b0;
      nop_q <= 1'b0;
      done_q <= 1'b0;
      mem_addr_q <= 12'h000;
      mem_we_q <= 1'b0;
      mem_wdata_q <= 8'h00;
    end else begin
      ext_q <= ext_d;
      bank_q <= bank_d;
      w_q <= w_d;
      index_q <= index_d;
      result_q <= result_d;
      skipped_q <= skipped_d;
      cycles_q <= cycles_d;
      foreign_q <= foreign_d;
      state_q <= state_d;
      dec_q <= dec_d;
      two_word_q <= two_word_d;
      instr_ready_q <= ready_d;
      discard_q <= discard_d;
      nop_q <= nop_d;
      done_q <= done_d;
      mem_addr_q <= mem_addr_d;
      mem_we_q <= mem_we_d;
      mem_wdata_q <= mem_wdata_d;
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  a_write_back: assert property (@(posedge core_clk) disable iff (!rst_b)
    state_q == ST_EXEC && dec_q.dest |=> mem_we_q && mem_wdata_q == $past(mem_rdata) - 8'h01)
    else $error("write-back of decremented value missing");

  a_accum_dest: assert property (@(posedge core_clk) disable iff (!rst_b)
    state_q == ST_EXEC && !dec_q.dest |=> !mem_we_q && w_q == $past(dec_result))
    else $error("accumulator destination wrong");

  a_skip_zero: assert property (@(posedge core_clk) disable iff (!rst_b)
    state_q == ST_EXEC && !dec_q.nonzero_kind |=> discard_q == ($past(mem_rdata) == 8'h01))
    else $error("skip-if-zero decision wrong");

  a_skip_nonzero: assert property (@(posedge core_clk) disable iff (!rst_b)
    state_q == ST_EXEC && dec_q.nonzero_kind |=> discard_q == ($past(mem_rdata) != 8'h01))
    else $error("skip-if-nonzero decision wrong");

  a_plain_one: assert property (@(posedge core_clk) disable iff (!rst_b)
    accept ##1 !take_skip |=> done_q && instr_ready_q && cycles_q == CYC_PLAIN)
    else $error("plain run not one cycle");

  a_skip_two: assert property (@(posedge core_clk) disable iff (!rst_b)
    discard_q && !two_word_q |-> nop_q ##1 done_q && !nop_q && cycles_q == CYC_SKIP)
    else $error("short skip not two cycles");

  a_skip_three: assert property (@(posedge core_clk) disable iff (!rst_b)
    discard_q && two_word_q |-> nop_q ##1 nop_q ##1 done_q && cycles_q == CYC_SKIP_LONG)
    else $error("long skip not three cycles");

  a_access_bank: assert property (@(posedge core_clk) disable iff (!rst_b)
    accept && !instr_word[8] && !ext_q |=> mem_addr_q == ($past(instr_word[7:0]) <= ACCESS_SPLIT
      ? {ACCESS_LOW_BANK, $past(instr_word[7:0])} : {ACCESS_HIGH_BANK, $past(instr_word[7:0])}))
    else $error("access bank address wrong");

  a_indexed_mode: assert property (@(posedge core_clk) disable iff (!rst_b)
    accept && !instr_word[8] && ext_q && instr_word[7:0] <= ACCESS_SPLIT
      |=> mem_addr_q == $past(index_q) + {4'h0, $past(instr_word[7:0])})
    else $error("indexed offset address wrong");

  a_bank_select: assert property (@(posedge core_clk) disable iff (!rst_b)
    accept && instr_word[8] |=> mem_addr_q == {$past(bank_q), $past(instr_word[7:0])})
    else $error("bank select address wrong");

  a_foreign_refused: assert property (@(posedge core_clk) disable iff (!rst_b)
    state_q == ST_IDLE && instr_valid && instr_ready_q && foreign
      |=> state_q == ST_IDLE && foreign_q)
    else $error("foreign opcode was taken");

endmodule

// ---- pkg/dskip_pkg.sv ----
// package: constants, register map and carrier types of the decrement-and-skip unit
package dskip_pkg;

  // ****************************************************************
  // register map, byte addresses on the axi4-lite port
  // ****************************************************************
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_BANK = 5'h04;
  localparam logic [4:0] REG_WREG = 5'h08;
  localparam logic [4:0] REG_INDEX = 5'h0c;
  localparam logic [4:0] REG_STATUS = 5'h10;

  // field positions
  localparam int CTRL_EXT_BIT = 0;
  localparam int STATUS_SKIP_BIT = 8;
  localparam int STATUS_CYC_LSB = 9;
  localparam int STATUS_FOREIGN_BIT = 12;

  // reset values
  localparam logic CTRL_RESET = 1'b0;
  localparam logic [3:0] BANK_RESET = 4'h0;
  localparam logic [7:0] WREG_RESET = 8'h00;
  localparam logic [11:0] INDEX_RESET = 12'h000;

  // ****************************************************************
  // instruction encoding and addressing
  // ****************************************************************
  localparam logic [5:0] OP_SKIP_ZERO = 6'h0b;
  localparam logic [5:0] OP_SKIP_NONZERO = 6'h13;
  localparam logic [7:0] ACCESS_SPLIT = 8'h5f;
  localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
  localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf;

  // instruction cycles spent per outcome
  localparam logic [1:0] CYC_PLAIN = 2'h1;
  localparam logic [1:0] CYC_SKIP = 2'h2;
  localparam logic [1:0] CYC_SKIP_LONG = 2'h3;

  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************************************
  // carrier types
  // ****************************************************************
  typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_SKIP, ST_SKIP2} exec_state_e;

  typedef struct packed {
    logic nonzero_kind;
    logic dest;
    logic access;
    logic [7:0] f;
  } decoded_s;

endpackage

// ---- dv/test_decrement_skip_execution.sv ----
// self-checking bench for the decrement-and-skip execution unit
module test_decrement_skip_execution;
  import dskip_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************************************
  // stimulus signals and counters
  // ****************************************************************
  logic core_clk, rst_b, instr_valid, next_two_word;
  logic [15:0] instr_word;
  logic [7:0] mem_rdata, w_exp;
  logic instr_ready_q, discard_q, nop_q, done_q, mem_we_q;
  logic [11:0] mem_addr_q;
  logic [7:0] mem_wdata_q;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int mismatches = 0;
  int cmp_count = 0;

  decrement_skip_execution decrement_skip_execution_i (.core_clk(core_clk), .rst_b(rst_b),
    .instr_valid(instr_valid), .instr_word(instr_word), .next_two_word(next_two_word),
    .instr_ready_q(instr_ready_q), .discard_q(discard_q), .nop_q(nop_q), .done_q(done_q),
    .mem_addr_q(mem_addr_q), .mem_rdata(mem_rdata), .mem_we_q(mem_we_q),
    .mem_wdata_q(mem_wdata_q), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

  // 50 mhz core clock
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("comparisons=%0d mismatches=%0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // write one word; awaddr and wdata are offered together, each dropped when taken
  task automatic axi_write(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s,
                           input logic [1:0] er);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    // no cycle limit here: only the watchdog may end a wait
    while (!(aw && w)) begin
      @(posedge core_clk);
      if (s_axi_awvalid && s_axi_awready) begin
        aw = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do begin
      @(posedge core_clk);
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    check(s_axi_bresp, er);
  endtask

  // read one word and compare data and response
  task automatic axi_read(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do begin
      @(posedge core_clk);
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    check(s_axi_rdata, ed);
    check(s_axi_rresp, er);
  endtask

  // issue one instruction, then judge cycles, write-back, skip and status
  task automatic run_instr(input logic [5:0] op, input logic d, input logic a,
                           input logic [7:0] f, input logic [7:0] rd, input logic two,
                           output logic [11:0] addr);
    logic [7:0] res;
    logic skip;
    logic [1:0] cyc;
    int n;
    logic [31:0] we, disc, nops;
    logic [7:0] wd;
    res = rd - 8'h01;
    skip = (op == OP_SKIP_ZERO) ? (res == 8'h00) : (res != 8'h00);
    cyc = skip ? (two ? CYC_SKIP_LONG : CYC_SKIP) : CYC_PLAIN;
    n = 0;
    we = 32'h0;
    disc = 32'h0;
    nops = 32'h0;
    wd = 8'h00;
    mem_rdata <= rd;
    next_two_word <= two;
    instr_word <= {op, d, a, f};
    instr_valid <= 1'b1;
    @(posedge core_clk);
    instr_valid <= 1'b0;
    // count edges after the taking edge until the finish pulse
    do begin
      @(posedge core_clk);
      n++;
      if (n == 1) addr = mem_addr_q;
      // 4-state sums so that an unknown strobe shows up as a mismatch
      we = we + {31'h0, mem_we_q};
      if (mem_we_q === 1'b1) wd = mem_wdata_q;
      disc = disc + {31'h0, discard_q};
      nops = nops + {31'h0, nop_q};
    end while (!done_q && n < 10);
    check(n, 32'(cyc) + 32'h1);
    check(we, {31'h0, d});
    if (d) check(wd, res);
    if (!d) w_exp = res;
    check(disc, {31'h0, skip});
    check(nops, skip ? (two ? 32'h2 : 32'h1) : 32'h0);
    axi_read(32'(REG_WREG), 32'(w_exp), RESP_OKAY);
    axi_read(32'(REG_STATUS), {21'h0, cyc, skip, res}, RESP_OKAY);
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset_values();
    axi_read(32'(REG_CTRL), 32'(CTRL_RESET), RESP_OKAY);
    axi_read(32'(REG_BANK), 32'(BANK_RESET), RESP_OKAY);
    axi_read(32'(REG_WREG), 32'(WREG_RESET), RESP_OKAY);
    axi_read(32'(REG_INDEX), 32'(INDEX_RESET), RESP_OKAY);
    axi_read(32'h14, 32'h0, RESP_SLVERR);
    axi_write(32'h14, 32'h55, 4'hf, RESP_SLVERR);
  endtask

  task automatic t_bank_and_access();
    logic [11:0] ad;
    axi_write(32'(REG_BANK), 32'h3, 4'hf, RESP_OKAY);
    run_instr(OP_SKIP_ZERO, 1'b1, 1'b1, 8'h20, 8'h01, 1'b0, ad);
    check(ad, 12'h320);
    run_instr(OP_SKIP_ZERO, 1'b0, 1'b0, 8'h10, 8'h05, 1'b0, ad);
    check(ad, {ACCESS_LOW_BANK, 8'h10});
    run_instr(OP_SKIP_NONZERO, 1'b1, 1'b0, 8'ha0, 8'h00, 1'b1, ad);
    check(ad, {ACCESS_HIGH_BANK, 8'ha0});
    run_instr(OP_SKIP_NONZERO, 1'b0, 1'b1, 8'hff, 8'h01, 1'b1, ad);
    check(ad, 12'h3ff);
  endtask

  // indexed offset at the 0x5f boundary and just above it
  task automatic t_indexed();
    logic [11:0] ad;
    axi_write(32'(REG_CTRL), 32'h1, 4'hf, RESP_OKAY);
    axi_write(32'(REG_INDEX), 32'h2f0, 4'hf, RESP_OKAY);
    run_instr(OP_SKIP_ZERO, 1'b1, 1'b0, ACCESS_SPLIT, 8'h03, 1'b0, ad);
    check(ad, 12'h34f);
    run_instr(OP_SKIP_ZERO, 1'b1, 1'b0, 8'h60, 8'h03, 1'b0, ad);
    check(ad, {ACCESS_HIGH_BANK, 8'h60});
    run_instr(OP_SKIP_NONZERO, 1'b1, 1'b1, 8'h10, 8'h09, 1'b0, ad);
    check(ad, 12'h310);
  endtask

  // a foreign opcode must never finish; its flag clears on write-one
  task automatic t_refused();
    logic [31:0] dn;
    dn = 32'h0;
    instr_word <= 16'h3123;
    instr_valid <= 1'b1;
    @(posedge core_clk);
    instr_valid <= 1'b0;
    repeat (5) begin
      @(posedge core_clk);
      dn = dn + {31'h0, done_q | mem_we_q};
    end
    check(dn, 32'h0);
    check(instr_ready_q, 1'b1);
    // last run left result 08, skip taken, two cycles: a refusal must not touch them
    axi_read(32'(REG_STATUS), 32'h1000 | 32'h508, RESP_OKAY);
    axi_write(32'(REG_STATUS), 32'h1000, 4'h2, RESP_OKAY);
    axi_read(32'(REG_STATUS), 32'h508, RESP_OKAY);
  endtask

  // ****************************************************************
  // main sequence and watchdog
  // ****************************************************************
  initial begin
    rst_b = 1'b0;
    instr_valid = 1'b0;
    instr_word = 16'h0000;
    next_two_word = 1'b0;
    mem_rdata = 8'h00;
    w_exp = WREG_RESET;
    s_axi_awaddr = 32'h0;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'h0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = 32'h0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    repeat (16) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge core_clk);
    t_reset_values();
    t_bank_and_access();
    t_indexed();
    t_refused();
    summarize();
  end

  // the whole run needs well under two thousand cycles
  initial begin
    repeat (20000) @(posedge core_clk);
    mismatches++;
    summarize();
  end

endmodule
